/* multimode_serial_port_regs.svh */
// Register indices, field positions, reset values and mode codes of the serial port.
`ifndef MULTIMODE_SERIAL_PORT_REGS_SVH
`define MULTIMODE_SERIAL_PORT_REGS_SVH

// Register indices; the byte address is four times the index.
`define MSP_IDX_CONTROL   16'hfe34
`define MSP_IDX_BUFFER    16'hfe35
`define MSP_IDX_DIVISOR   16'hfe36
`define MSP_IDX_OVERRIDE  16'hfe37

// Control register field positions.
`define MSP_CTL_IE        0
`define MSP_CTL_END       1
`define MSP_CTL_OVR       2
`define MSP_CTL_DIR       3
`define MSP_CTL_REC       4
`define MSP_CTL_RUN       5
`define MSP_CTL_MODE_LO   6
`define MSP_CTL_MODE_HI   7

// Pin override register field positions.
`define MSP_OVR_CLK_EN    0
`define MSP_OVR_CLK_LVL   1
`define MSP_OVR_DAT_EN    2
`define MSP_OVR_DAT_LVL   3

// Reset values.
`define MSP_RST_CONTROL   8'h00
`define MSP_RST_BUFFER    9'h000
`define MSP_RST_DIVISOR   8'h00
`define MSP_RST_OVERRIDE  4'h0

// Mode codes.
`define MSP_MODE_SYNC     2'h0
`define MSP_MODE_UART     2'h1
`define MSP_MODE_MASTER   2'h2
`define MSP_MODE_SLAVE    2'h3

// Last bit index of each frame kind, and the bits in a byte.
`define MSP_LAST_SYNC     4'h7
`define MSP_LAST_UART     4'h9
`define MSP_LAST_MASTER   4'h8
`define MSP_BYTE_BITS     4'h8

`endif

/* multimode_serial_port_pkg.sv */
// Types shared by the multimode serial port.
package multimode_serial_port_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_START,
    ST_LOW,
    ST_HIGH,
    ST_HOLD,
    ST_SLV_BIT,
    ST_SLV_STR,
    ST_SLV_DLY,
    ST_SLV_ACK,
    ST_SLV_PARK
  } state_t;

endpackage

/* multimode_serial_port.sv */
// Multimode serial port: sync shifter, async frame, two-wire master and slave, Wishbone registers.
//
// Function
// - Two mode bits pick sync shift, async one stop, bus master or bus slave.
// - Master run emits start, eight buffer bits, then a released ninth bit.
// - Master send: clearing end sends next byte plus released ninth bit, no start.
// - Modes 1 to 3 capture the ninth received bit into buffer bit 8.
// - Master losing contention clears run and raises no end flag.
// - Master receive: clearing end shifts eight bits in, then drives buffer bit 8.
// - Slave with receive selected sets run on a start condition and receives.
// - Slave holds clock low on eighth falling edge and sets end.
// - Slave start condition with receive selected sets the sticky overrun flag.
// - Slave releases the clock divisor plus one cycles after end is cleared.
// - Slave stop condition clears run and sets end.
// - A start in mid receive restarts the bit count, eight more clocks needed.
// - Slave transmit with high ninth bit clears run and releases data.
// - Slave buffer bit 8 changes only at the ninth clock rise; master samples it at the end of the ninth high half.
// - Clearing run and end together ends a slave transfer, clock released.
// - Receive bit: one receives, zero sends; direction bit: one sends MSB first.
// - Overrun sets on stray clock fall while running, on a stop condition in master mode, or end set while set.
// - End sets at transfer end, software clears; end and enable request interrupt.
// - Buffer low byte loads the shifter at start and returns after eight bits.
// - Divisor write reloads the rate counter; half periods of divisor plus one, four times that in async mode.
`include "multimode_serial_port_regs.svh"

module multimode_serial_port #(
  parameter int ADR_W = 18
) (
  input  wire logic             I_MCLK,
  input  wire logic             I_RESET_N,
  input  wire logic             I_CE,
  input  wire logic             I_WB_CYC,
  input  wire logic             I_WB_STB,
  input  wire logic             I_WB_WE,
  input  wire logic [ADR_W-1:0] I_WB_ADR,
  input  wire logic [31:0]      I_WB_DAT,
  input  wire logic [3:0]       I_WB_SEL,
  output logic                  O_WB_ACK,
  output logic [31:0]           O_WB_DAT,
  input  wire logic             I_SER_CLK_I,
  output logic                  O_SER_CLK_O,
  output logic                  O_SER_CLK_OE_N,
  input  wire logic             I_SER_DAT_I,
  output logic                  O_SER_DAT_O,
  output logic                  O_SER_DAT_OE_N,
  output logic                  O_IRQ
);
  import multimode_serial_port_pkg::*;

  // ---------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------

  // Bit presented by the shifter for the selected order.
  function automatic logic shout(input logic [7:0] s, input logic msb);
    return msb ? s[7] : s[0];
  endfunction

  // Shifter after one bit enters at the far end.
  function automatic logic [7:0] shin(input logic [7:0] s, input logic b, input logic msb);
    return msb ? {s[6:0], b} : {b, s[7:1]};
  endfunction

  // Half bit period minus one, in system cycles.
  function automatic logic [9:0] half_load(input logic [1:0] m, input logic [7:0] v);
    return (m == `MSP_MODE_UART) ? {v, 2'b11} : {2'b00, v};
  endfunction

  // Line level for the current bit; one means released.
  function automatic logic bit_level(input logic [1:0] m, input logic [3:0] c, input logic rx,
                                     input logic [7:0] s, input logic msb, input logic b8);
    logic lvl;
    lvl = rx ? 1'b1 : shout(s, msb);
    if (m == `MSP_MODE_UART) begin
      if (c == 4'h0) begin
        lvl = 1'b0;
      end else if (c == `MSP_LAST_UART) begin
        lvl = 1'b1;
      end
    end else if (m == `MSP_MODE_MASTER && c == `MSP_LAST_MASTER) begin
      lvl = rx ? b8 : 1'b1;
    end
    return lvl;
  endfunction

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  logic [1:0]  clk_sync_ff;
  logic [1:0]  dat_sync_ff;
  logic        clk_prev_ff;
  logic        dat_prev_ff;
  logic [1:0]  mode_ff;
  logic        run_ff;
  logic        rec_ff;
  logic        dir_ff;
  logic        ovr_ff;
  logic        end_ff;
  logic        ie_ff;
  logic [8:0]  buf_ff;
  logic [7:0]  div_ff;
  logic [3:0]  ovrd_ff;
  logic        ack_ff;
  logic [31:0] rdat_ff;
  logic        irq_ff;
  state_t      state_ff;
  logic [3:0]  cnt_ff;
  logic [7:0]  sh_ff;
  logic [9:0]  rate_ff;
  logic        clk_low_ff;
  logic        dat_low_ff;
  logic        prev_rec_ff;
  logic        clk_oe_n_ff;
  logic        dat_oe_n_ff;
  logic        cp_low_ff;
  logic        b8_set_ff;
  logic        b8_val_ff;
  logic        ev_end_ff;
  logic        ev_ovr_ff;
  logic        ev_run_set_ff;
  logic        ev_run_clr_ff;

  // ---------------------------------------------------------------------
  // Line synchronisers and condition detection
  // ---------------------------------------------------------------------

  // Two flip-flops per line, then one more stage for edge detection.
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      clk_sync_ff <= 2'b11;
      dat_sync_ff <= 2'b11;
      clk_prev_ff <= 1'b1;
      dat_prev_ff <= 1'b1;
    end else if (I_CE) begin
      clk_sync_ff <= {clk_sync_ff[0], I_SER_CLK_I};
      dat_sync_ff <= {dat_sync_ff[0], I_SER_DAT_I};
      clk_prev_ff <= clk_sync_ff[1];
      dat_prev_ff <= dat_sync_ff[1];
    end
  end

  // Edges and bus conditions seen on the synchronised lines.
  wire clk_s      = clk_sync_ff[1];
  wire dat_s      = dat_sync_ff[1];
  wire clk_rise   = clk_s & ~clk_prev_ff;
  wire clk_fall   = ~clk_s & clk_prev_ff;
  wire dat_fall   = ~dat_s & dat_prev_ff;
  wire start_cond = clk_s & clk_prev_ff & dat_prev_ff & ~dat_s;
  wire stop_cond  = clk_s & clk_prev_ff & ~dat_prev_ff & dat_s;

  // ---------------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------------

  // Request decode; a request is taken once, in the cycle before ack.
  wire        bus_req = I_WB_CYC & I_WB_STB & ~ack_ff;
  wire [15:0] idx     = I_WB_ADR[17:2];
  wire        wr_ok   = bus_req & I_WB_WE & I_WB_SEL[0];
  wire        wr_ctl  = wr_ok & (idx == `MSP_IDX_CONTROL);
  wire        wr_buf  = wr_ok & (idx == `MSP_IDX_BUFFER);
  wire        wr_b8   = bus_req & I_WB_WE & I_WB_SEL[1] & (idx == `MSP_IDX_BUFFER);
  wire        wr_div  = wr_ok & (idx == `MSP_IDX_DIVISOR);
  wire        wr_ovrd = wr_ok & (idx == `MSP_IDX_OVERRIDE);
  wire        wr_run  = I_WB_DAT[`MSP_CTL_RUN];
  wire [1:0]  wr_mode = I_WB_DAT[`MSP_CTL_MODE_HI:`MSP_CTL_MODE_LO];
  wire        start_req = wr_ctl & wr_run & ~run_ff & ~(wr_mode == `MSP_MODE_SLAVE)
                          & ~(wr_mode == `MSP_MODE_UART & I_WB_DAT[`MSP_CTL_REC]);
  wire        clr_end_req = wr_ctl & end_ff & ~I_WB_DAT[`MSP_CTL_END];

  // Ack one cycle after the request; unmapped reads return zero.
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else if (I_CE) begin
      ack_ff  <= bus_req;
      rdat_ff <= 32'h0000_0000;
      if (bus_req & ~I_WB_WE) begin
        case (idx)
          `MSP_IDX_CONTROL:  rdat_ff <= {24'h00_0000, mode_ff, run_ff, rec_ff, dir_ff, ovr_ff, end_ff, ie_ff};
          `MSP_IDX_BUFFER:   rdat_ff <= {23'h00_0000, buf_ff};
          `MSP_IDX_DIVISOR:  rdat_ff <= {24'h00_0000, div_ff};
          `MSP_IDX_OVERRIDE: rdat_ff <= {28'h000_0000, ovrd_ff};
          default:           rdat_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------

  // Control flags; hardware events are applied after the write so they win.
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      {mode_ff, run_ff, rec_ff, dir_ff, ovr_ff, end_ff, ie_ff} <= `MSP_RST_CONTROL;
    end else if (I_CE) begin
      if (wr_ctl) begin
        mode_ff <= wr_mode;
        run_ff  <= wr_run;
        rec_ff  <= I_WB_DAT[`MSP_CTL_REC];
        dir_ff  <= I_WB_DAT[`MSP_CTL_DIR];
        ovr_ff  <= I_WB_DAT[`MSP_CTL_OVR];
        end_ff  <= I_WB_DAT[`MSP_CTL_END];
        ie_ff   <= I_WB_DAT[`MSP_CTL_IE];
      end
      if (ev_run_clr_ff) begin
        run_ff <= 1'b0;
      end
      if (ev_run_set_ff) begin
        run_ff <= 1'b1;
      end
      if (ev_end_ff) begin
        end_ff <= 1'b1;
      end
      if (ev_ovr_ff | (ev_end_ff & end_ff)) begin
        ovr_ff <= 1'b1;
      end
    end
  end

  // Serial buffer; the shifter copy and ninth bit capture win over a write.
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      buf_ff <= `MSP_RST_BUFFER;
    end else if (I_CE) begin
      if (wr_buf) begin
        buf_ff[7:0] <= I_WB_DAT[7:0];
      end
      if (wr_b8) begin
        buf_ff[8] <= I_WB_DAT[8];
      end
      if (cp_low_ff) begin
        buf_ff[7:0] <= sh_ff;
      end
      if (b8_set_ff) begin
        buf_ff[8] <= b8_val_ff;
      end
    end
  end

  // Divisor and pin override registers.
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      div_ff  <= `MSP_RST_DIVISOR;
      ovrd_ff <= `MSP_RST_OVERRIDE;
    end else if (I_CE) begin
      if (wr_div) begin
        div_ff <= I_WB_DAT[7:0];
      end
      if (wr_ovrd) begin
        ovrd_ff <= I_WB_DAT[3:0];
      end
    end
  end

  // ---------------------------------------------------------------------
  // Transfer engine
  // ---------------------------------------------------------------------

  // Rate tick, bit sequencing and line drive for all four modes.
  wire       tick = (rate_ff == 10'h000);
  wire [3:0] last = (mode_ff == `MSP_MODE_SYNC) ? `MSP_LAST_SYNC :
                    (mode_ff == `MSP_MODE_UART) ? `MSP_LAST_UART : `MSP_LAST_MASTER;
  wire       sample_low = (mode_ff == `MSP_MODE_UART);

  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      state_ff      <= ST_IDLE;
      cnt_ff        <= 4'h0;
      sh_ff         <= 8'h00;
      rate_ff       <= 10'h000;
      clk_low_ff    <= 1'b0;
      dat_low_ff    <= 1'b0;
      prev_rec_ff   <= 1'b0;
      cp_low_ff     <= 1'b0;
      b8_set_ff     <= 1'b0;
      b8_val_ff     <= 1'b0;
      ev_end_ff     <= 1'b0;
      ev_ovr_ff     <= 1'b0;
      ev_run_set_ff <= 1'b0;
      ev_run_clr_ff <= 1'b0;
    end else if (I_CE) begin
      cp_low_ff     <= 1'b0;
      b8_set_ff     <= 1'b0;
      ev_end_ff     <= 1'b0;
      ev_run_set_ff <= 1'b0;
      ev_run_clr_ff <= 1'b0;
      ev_ovr_ff     <= (state_ff == ST_IDLE) & run_ff & clk_fall & (mode_ff != `MSP_MODE_MASTER)
                       | (mode_ff == `MSP_MODE_MASTER) & stop_cond;
      rate_ff <= tick ? half_load(mode_ff, div_ff) : rate_ff - 10'h001;
      case (state_ff)
        ST_IDLE: begin
          clk_low_ff <= 1'b0;
          dat_low_ff <= 1'b0;
          rate_ff    <= half_load(mode_ff, div_ff);
          cnt_ff     <= 4'h0;
          if (start_req) begin
            sh_ff    <= buf_ff[7:0];
            rate_ff  <= half_load(wr_mode, div_ff);
            state_ff <= (wr_mode == `MSP_MODE_MASTER) ? ST_START : ST_LOW;
            if (wr_mode == `MSP_MODE_MASTER) begin
              dat_low_ff <= 1'b1;
            end
          end else if (mode_ff == `MSP_MODE_UART & rec_ff & dat_fall) begin
            ev_run_set_ff <= 1'b1;
            state_ff      <= ST_LOW;
          end
        end
        ST_START: begin
          if (tick) begin
            clk_low_ff <= 1'b1;
            state_ff   <= ST_LOW;
          end
        end
        ST_LOW: begin
          clk_low_ff <= (mode_ff != `MSP_MODE_UART);
          dat_low_ff <= ~bit_level(mode_ff, cnt_ff, rec_ff, sh_ff, dir_ff, buf_ff[8]);
          if (tick) begin
            clk_low_ff <= 1'b0;
            state_ff   <= ST_HIGH;
            if (sample_low & (cnt_ff != 4'h0) & (cnt_ff != `MSP_LAST_UART)) begin
              sh_ff <= shin(sh_ff, dat_s, dir_ff);
            end
            if (sample_low & (cnt_ff == `MSP_LAST_UART)) begin
              b8_set_ff <= 1'b1;
              b8_val_ff <= dat_s;
            end
          end
        end
        ST_HIGH: begin
          if (mode_ff == `MSP_MODE_MASTER & ~clk_s) begin
            rate_ff <= half_load(mode_ff, div_ff);
          end else if (tick) begin
            if (~sample_low & (cnt_ff < `MSP_BYTE_BITS)) begin
              sh_ff <= shin(sh_ff, dat_s, dir_ff);
            end
            if (mode_ff == `MSP_MODE_MASTER & cnt_ff == `MSP_LAST_MASTER) begin
              b8_set_ff <= 1'b1;
              b8_val_ff <= dat_s;
            end
            if (cnt_ff == (sample_low ? `MSP_BYTE_BITS : `MSP_LAST_SYNC)) begin
              cp_low_ff <= 1'b1;
            end
            if (mode_ff == `MSP_MODE_MASTER & ~rec_ff & (cnt_ff < `MSP_BYTE_BITS) & ~dat_low_ff & ~dat_s) begin
              ev_run_clr_ff <= 1'b1;
              cp_low_ff     <= 1'b0;
              dat_low_ff    <= 1'b0;
              state_ff      <= ST_IDLE;
            end else if (cnt_ff == last) begin
              ev_end_ff     <= 1'b1;
              ev_run_clr_ff <= (mode_ff != `MSP_MODE_MASTER);
              dat_low_ff    <= 1'b0;
              state_ff      <= (mode_ff == `MSP_MODE_MASTER) ? ST_HOLD : ST_IDLE;
            end else begin
              cnt_ff     <= cnt_ff + 4'h1;
              clk_low_ff <= (mode_ff != `MSP_MODE_UART);
              state_ff   <= ST_LOW;
            end
          end
        end
        ST_HOLD: begin
          clk_low_ff <= clr_end_req & wr_run;
          dat_low_ff <= 1'b0;
          if (clr_end_req) begin
            state_ff <= wr_run ? ST_LOW : ST_IDLE;
            sh_ff    <= buf_ff[7:0];
            cnt_ff   <= 4'h0;
            rate_ff  <= half_load(mode_ff, div_ff);
          end
        end
        ST_SLV_BIT: begin
          if (clk_rise) begin
            sh_ff  <= shin(sh_ff, dat_s, dir_ff);
            cnt_ff <= cnt_ff + 4'h1;
          end
          if (clk_fall & cnt_ff == `MSP_BYTE_BITS) begin
            clk_low_ff <= 1'b1;
            dat_low_ff <= 1'b0;
            cp_low_ff  <= 1'b1;
            ev_end_ff  <= 1'b1;
            state_ff   <= ST_SLV_STR;
          end else if (clk_fall) begin
            dat_low_ff <= ~prev_rec_ff & ~shout(sh_ff, dir_ff);
          end
        end
        ST_SLV_STR: begin
          clk_low_ff <= 1'b1;
          if (clr_end_req & ~wr_run) begin
            clk_low_ff <= 1'b0;
            state_ff   <= ST_SLV_PARK;
          end else if (clr_end_req) begin
            sh_ff      <= buf_ff[7:0];
            dat_low_ff <= prev_rec_ff;
            rate_ff    <= {2'b00, div_ff};
            state_ff   <= ST_SLV_DLY;
          end
        end
        ST_SLV_DLY: begin
          if (tick) begin
            clk_low_ff <= 1'b0;
            state_ff   <= ST_SLV_ACK;
          end
        end
        ST_SLV_ACK: begin
          if (clk_rise) begin
            b8_set_ff <= 1'b1;
            b8_val_ff <= dat_s;
            if (~prev_rec_ff & dat_s) begin
              ev_run_clr_ff <= 1'b1;
              dat_low_ff    <= 1'b0;
              state_ff      <= ST_SLV_PARK;
            end
          end else if (clk_fall) begin
            cnt_ff      <= 4'h0;
            prev_rec_ff <= rec_ff;
            dat_low_ff  <= ~rec_ff & ~shout(sh_ff, dir_ff);
            state_ff    <= ST_SLV_BIT;
          end
        end
        ST_SLV_PARK: begin
          clk_low_ff <= 1'b0;
          dat_low_ff <= 1'b0;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
      if (wr_div) begin
        rate_ff <= half_load(mode_ff, I_WB_DAT[7:0]);
      end
      // Slave bus conditions override whatever the sequencer was doing.
      if (mode_ff == `MSP_MODE_SLAVE & start_cond & rec_ff) begin
        ev_run_set_ff <= 1'b1;
        ev_ovr_ff     <= 1'b1;
        cnt_ff        <= 4'h0;
        prev_rec_ff   <= 1'b1;
        clk_low_ff    <= 1'b0;
        dat_low_ff    <= 1'b0;
        state_ff      <= ST_SLV_BIT;
      end else if (mode_ff == `MSP_MODE_SLAVE & stop_cond & (run_ff | state_ff != ST_IDLE)) begin
        ev_run_clr_ff <= 1'b1;
        ev_end_ff     <= 1'b1;
        clk_low_ff    <= 1'b0;
        dat_low_ff    <= 1'b0;
        state_ff      <= ST_IDLE;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------

  // Open-drain enables, with the software overrides taking precedence.
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      clk_oe_n_ff <= 1'b1;
      dat_oe_n_ff <= 1'b1;
      irq_ff      <= 1'b0;
    end else if (I_CE) begin
      clk_oe_n_ff <= ovrd_ff[`MSP_OVR_CLK_EN] ? ovrd_ff[`MSP_OVR_CLK_LVL] : ~clk_low_ff;
      dat_oe_n_ff <= ovrd_ff[`MSP_OVR_DAT_EN] ? ovrd_ff[`MSP_OVR_DAT_LVL] : ~dat_low_ff;
      irq_ff      <= end_ff & ie_ff;
    end
  end

  // Port assignments; the driven level of an open-drain line is always low.
  assign O_WB_ACK       = ack_ff;
  assign O_WB_DAT       = rdat_ff;
  assign O_SER_CLK_O    = 1'b0;
  assign O_SER_CLK_OE_N = clk_oe_n_ff;
  assign O_SER_DAT_O    = 1'b0;
  assign O_SER_DAT_OE_N = dat_oe_n_ff;
  assign O_IRQ          = irq_ff;

endmodule

/* port_monitor.sv */
// Concurrent checks on the serial port top-level ports.
`include "multimode_serial_port_regs.svh"
module port_monitor #(parameter int ADR_W = 18) (
  input wire logic             I_MCLK,
  input wire logic             I_RESET_N,
  input wire logic             I_CE,
  input wire logic             I_WB_CYC,
  input wire logic             I_WB_STB,
  input wire logic             I_WB_WE,
  input wire logic [ADR_W-1:0] I_WB_ADR,
  input wire logic [31:0]      I_WB_DAT,
  input wire logic [3:0]       I_WB_SEL,
  input wire logic             O_WB_ACK,
  input wire logic [31:0]      O_WB_DAT,
  input wire logic             O_SER_CLK_OE_N,
  input wire logic             O_SER_DAT_OE_N,
  input wire logic             O_IRQ
);
  logic [7:0] div_ff;
  logic [1:0] mode_ff;
  logic       ie_ff;
  logic       frc_ff;
  logic [8:0] lo_ff;
  wire        wr  = O_WB_ACK && I_WB_WE && I_WB_SEL[0];
  wire [15:0] idx = I_WB_ADR[17:2];
  // Mirrors the software settings from completed writes.
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      div_ff <= 8'h00;
      mode_ff <= 2'h0;
      ie_ff <= 1'b0;
      frc_ff <= 1'b0;
    end else if (wr && idx == `MSP_IDX_CONTROL) begin
      mode_ff <= I_WB_DAT[7:6];
      ie_ff <= I_WB_DAT[0];
    end else if (wr && idx == `MSP_IDX_DIVISOR) begin
      div_ff <= I_WB_DAT[7:0];
    end else if (wr && idx == `MSP_IDX_OVERRIDE) begin
      frc_ff <= I_WB_DAT[0] | I_WB_DAT[2];
    end
  end
  // Counts the cycles the port holds the clock line low.
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N || O_SER_CLK_OE_N) begin
      lo_ff <= 9'h000;
    end else begin
      lo_ff <= lo_ff + 9'h001;
    end
  end
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);
  sequence bus_req;
    I_CE && I_WB_CYC && I_WB_STB && !O_WB_ACK;
  endsequence
  sequence end_clear;
    wr && idx == `MSP_IDX_CONTROL && !I_WB_DAT[1] && !O_SER_CLK_OE_N;
  endsequence
  ack_one_a: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack held too long");
  ack_answer_a: assert property (bus_req |=> O_WB_ACK) else $error("request not acked");
  rdat_idle_a: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0) else $error("read data outside ack");
  half_period_a: assert property (mode_ff == `MSP_MODE_MASTER && !frc_ff && $rose(O_SER_CLK_OE_N)
    |-> lo_ff == 9'(div_ff) + 9'h001) else $error("clock low half wrong");
  start_hold_a: assert property (mode_ff == `MSP_MODE_MASTER && !frc_ff && O_SER_CLK_OE_N
    && $fell(O_SER_DAT_OE_N) |=> O_SER_CLK_OE_N) else $error("start without clock high");
  release_a: assert property (mode_ff == `MSP_MODE_SLAVE ##0 end_clear
    |-> ##[1:10] O_SER_CLK_OE_N) else $error("stretched clock not released");
  stretch_irq_a: assert property (mode_ff == `MSP_MODE_SLAVE && ie_ff && $fell(O_SER_CLK_OE_N)
    |-> ##[0:4] O_IRQ) else $error("stretch without interrupt");
  irq_enable_a: assert property (O_IRQ |-> ie_ff || $past(ie_ff)) else $error("irq while disabled");
endmodule

/* bus_peer.sv */
// Behavioural two-wire peer: acknowledging slave and simple master.
module bus_peer (
  input  wire logic i_clk,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl_oe_n,
  output logic      o_sda_oe_n,
  output logic [7:0] o_rx,
  output int        o_starts
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt = 0;
  logic mst = 1'b0;
  initial begin
    o_scl_oe_n = 1'b1;
    o_sda_oe_n = 1'b1;
    o_rx = 8'h00;
    o_starts = 0;
  end
  // Data falling while the clock is high is a start.
  always @(negedge i_sda) if (i_scl === 1'b1) begin
    cnt = 0;
    o_starts++;
  end
  // Each clock rise but the ninth shifts a data bit in, first bit on top.
  always @(posedge i_scl) begin
    if (cnt == 9) cnt = 0;
    if (cnt < 8) o_rx = {o_rx[6:0], i_sda};
    cnt++;
  end
  // As slave, pulls data low through the ninth clock.
  always @(negedge i_scl) if (!mst) o_sda_oe_n <= (cnt != 8);
  // Waits half of the 800 ns bit.
  task automatic half();
    repeat (4) @(posedge i_clk);
  endtask
  // Releases the clock and waits, bounded, while it is stretched.
  task automatic rise();
    o_scl_oe_n <= 1'b1;
    for (int w = 0; w < 800 && i_scl !== 1'b1; w++) @(posedge i_clk);
    half();
  endtask
  // Sends a first or repeated start.
  task automatic send_start();
    mst = 1'b1;
    o_sda_oe_n <= 1'b1;
    half();
    rise();
    o_sda_oe_n <= 1'b0;
    half();
    o_scl_oe_n <= 1'b0;
  endtask
  // Sends the top n bits of b; a whole byte also clocks the acknowledge slot.
  task automatic send(input logic [7:0] b, input int n, output logic ack);
    ack = 1'b1;
    for (int k = 0; k <= n; k++) begin
      @(posedge i_clk);
      o_sda_oe_n <= (k < 8) ? b[7-k] : 1'b1;
      half();
      if (k < n || n == 8) rise();
      ack = i_sda;
      o_scl_oe_n <= 1'b0;
    end
  endtask
  // Data rising while the clock is high ends the transfer.
  task automatic send_stop();
    @(posedge i_clk);
    o_sda_oe_n <= 1'b0;
    half();
    rise();
    o_sda_oe_n <= 1'b1;
    half();
    mst = 1'b0;
  endtask
endmodule

/* tb.sv */
// Self-checking bench for the multimode serial port.
`include "multimode_serial_port_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, irq, scl_oe_n, sda_oe_n, p_scl, p_sda, a;
  logic [17:0] adr = '0;
  logic [31:0] wdat = '0, rdat, q;
  logic [16:0] s = 17'h1214d;
  logic [7:0] rx;
  int starts, n, failures = 0, checks = 0;
  wire scl = scl_oe_n & p_scl;
  wire sda = sda_oe_n & p_sda;
  always #50 clk = ~clk;
  multimode_serial_port i_multimode_serial_port (.I_MCLK(clk), .I_RESET_N(rst_n), .I_CE(1'b1),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(4'hf),
    .O_WB_ACK(ack), .O_WB_DAT(rdat), .I_SER_CLK_I(scl), .O_SER_CLK_O(), .O_SER_CLK_OE_N(scl_oe_n),
    .I_SER_DAT_I(sda), .O_SER_DAT_O(), .O_SER_DAT_OE_N(sda_oe_n), .O_IRQ(irq));
  bus_peer i_bus_peer (.i_clk(clk), .i_scl(scl), .i_sda(sda), .o_scl_oe_n(p_scl),
    .o_sda_oe_n(p_sda), .o_rx(rx), .o_starts(starts));
  function automatic logic [16:0] step(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int k = 0; k < 8; k++) rev[k] = v[7-k];
  endfunction
  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  // One classic cycle, held until ack is sampled.
  task automatic bus(input logic w, input logic [15:0] i, input logic [31:0] d);
    int t = 0;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= d;
    do begin @(posedge clk); t++; end while (ack !== 1'b1 && t < 50);
    if (t == 50) failures++;
    q = rdat;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    bus(1'b1, i, d);
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, i, 32'h0);
    cmp($sformatf("reg %h", i), e, q & m);
  endtask
  task automatic wait_irq();
    int t = 0;
    repeat (2) @(posedge clk);
    while (irq !== 1'b1 && t < 3000) begin @(posedge clk); t++; end
    if (t == 3000) failures++;
  endtask
  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(`MSP_IDX_CONTROL, 32'h0, 32'hffffffff);
    rd(`MSP_IDX_BUFFER, 32'h0, 32'hffffffff);
    rd(16'hfe38, 32'h0, 32'hffffffff);
    s = step(s);
    wr(`MSP_IDX_DIVISOR, {24'h0, s[7:0]});
    rd(`MSP_IDX_DIVISOR, {24'h0, s[7:0]}, 32'hffffffff);
    wr(`MSP_IDX_DIVISOR, 32'h3);
    for (int o = 0; o < 3; o++) begin
      s = step(s);
      n = starts;
      if (o == 1) for (int k = 0; k < 3; k++) wr(`MSP_IDX_OVERRIDE, {28'h0, 4'(12'h0c1 >> (4 * k))});
      wr(`MSP_IDX_BUFFER, {23'h0, 1'b1, s[7:0]});
      if (o < 2) wr(`MSP_IDX_CONTROL, 32'h81 | (o << 3));
      wr(`MSP_IDX_CONTROL, (o < 2) ? 32'ha1 | (o << 3) : 32'ha9);
      wait_irq();
      rd(`MSP_IDX_BUFFER, {23'h0, 1'b0, s[7:0]}, 32'h1ff);
      cmp("peer byte", {24'h0, (o > 0) ? s[7:0] : rev(s[7:0])}, {24'h0, rx});
      cmp("starts", (o < 2) ? n + 1 : n, starts);
    end
    for (int k = 0; k < 6; k++) wr(`MSP_IDX_OVERRIDE, {28'h0, 4'(32'h0c4510 >> (4 * k))});
    rd(`MSP_IDX_CONTROL, 32'h4, 32'h4);
    wr(`MSP_IDX_BUFFER, 32'h1ff);
    wr(`MSP_IDX_CONTROL, 32'hd9);
    s = step(s);
    i_bus_peer.send_start();
    i_bus_peer.send(~s[7:0], 4, a);
    i_bus_peer.send_start();
    fork
      i_bus_peer.send(s[7:0], 8, a);
      begin
        wait_irq();
        rd(`MSP_IDX_CONTROL, 32'hff, 32'hff);
        rd(`MSP_IDX_BUFFER, {23'h0, 1'b1, s[7:0]}, 32'h1ff);
        wr(`MSP_IDX_CONTROL, 32'hf9);
      end
    join
    cmp("slave ack", 32'h0, {31'h0, a});
    rd(`MSP_IDX_BUFFER, {23'h0, 1'b0, s[7:0]}, 32'h1ff);
    i_bus_peer.send_stop();
    wait_irq();
    rd(`MSP_IDX_CONTROL, 32'hdb, 32'hfb);
    final_report();
  end
endmodule
bind multimode_serial_port port_monitor #(.ADR_W(ADR_W)) i_port_monitor (.I_MCLK(I_MCLK),
  .I_RESET_N(I_RESET_N), .I_CE(I_CE), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE),
  .I_WB_ADR(I_WB_ADR), .I_WB_DAT(I_WB_DAT), .I_WB_SEL(I_WB_SEL), .O_WB_ACK(O_WB_ACK),
  .O_WB_DAT(O_WB_DAT), .O_SER_CLK_OE_N(O_SER_CLK_OE_N), .O_SER_DAT_OE_N(O_SER_DAT_OE_N), .O_IRQ(O_IRQ));
